/* src/smpc_ctrl.sv */
// Stop-mode power controller: depth selection, power and clock gating,
// wakeup handling, pin latches and the periodic wakeup source.
// Assumes the core pulses stop_exec once per executed stop instruction and
// that every pin input is already synchronous to pclk.
//
// Operation
// R1 - Shallowest stop halts all clocks and oscillator, comparator off, regulator standby; code: comparator standby, oscillator on with low-voltage reset.
// R2 - Shallowest stop keeps registers, logic and RAM; pins are not latched.
// R3 - Shallowest stop ends on reset pin, enabled interrupt pins or periodic wakeup.
// R4 - Reset pin wake resets; interrupt wakes take their vector without reset.
// R5 - An independent 1 kHz source drives periodic wakeup from intermediate and shallowest stop; code: tick counted from pclk.
// R6 - Period select zero disables the periodic function and its source.
// R7 - Debug entry enable keeps debug clocks and full regulation during stop.
// R8 - Debug entry enable forces shallowest stop with oscillator and regulator on.
// R9 - Stopped: status debug commands return a stop error, others unavailable.
// R10 - With debug entry, the background command ends stop into background mode.
// R11 - Low-voltage reset enable keeps the regulator on and forces shallowest stop.
// R12 - Every stop mode stops peripheral clocks, even with debug clocks running.
// R13 - Intermediate stop latches pins until software writes the release acknowledge.
// R14 - Deepest stop forces every I/O pin to its reset state.
// R15 - Deep wakes reset registers; RAM kept after intermediate, lost after deepest.
// R16 - Peripheral clocks halt in stop; deep wakes leave those modules reset.
// R17 - Comparator in standby during stop, reset after deep wakes.
// R18 - Keypad pins: interrupts in shallowest stop, active-low wake inputs deeper.
// R19 - Regulator standby in every stop unless low-voltage reset or debug enabled.
// R20 - Depth from power-down and partial bits at the stop instruction.
// R21 - Stop instruction not allowed forces an illegal-opcode reset instead.
// R22 - Intermediate wake sets a flag that holds until acknowledge is written.
// R23 - Depth, debug and low-voltage controls are sampled when stop executes.
//
// The APB register port and the register offsets were decided locally.

`timescale 1ns/1ns

module smpc_ctrl #(
   parameter int PWK_TICK_CYCLES = smpc_pkg::PWK_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Processor core
   input  wire logic        stop_exec,
   output logic             illegal_op_reset,
   output logic             cpu_clk_en,
   output logic             wake_reset,
   output logic             wake_irq,
   output logic      [2:0]  wake_cause,
   output logic             pwk_irq,
   // Power, clocks and peripherals
   output logic             osc_en,
   output logic             regulator_full,
   output logic             periph_clk_en,
   output logic             periph_reset,
   output logic             comparator_standby,
   output logic             ram_retain,
   output logic             pwk_src_en,
   // Pins and wakeup sources
   input  wire logic        reset_pin_n,
   input  wire logic        irq_pin_n,
   input  wire logic        irq_req,
   input  wire logic [7:0]  keypad_pins_n,
   input  wire logic        keypad_irq,
   output logic             pins_latched,
   output logic             pins_force_default,
   output logic             keypad_wake_mode,
   // Background debug controller
   input  wire logic        dbg_background_cmd,
   input  wire logic        dbg_status_query,
   output logic             debug_clk_en,
   output logic             dbg_cmds_avail,
   output logic             dbg_status_err,
   output logic             dbg_enter_background
);
   import smpc_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   smpc_state_t                  state_q,   state_d;
   logic [1:0]                   depth_q,   depth_d;
   logic [15:0]                  cfg_q,     cfg_d;
   logic                         flag_q,    flag_d;
   logic                         latch_q,   latch_d;
   logic                         dbg_q,     dbg_d;
   logic                         lvr_q,     lvr_d;
   logic [2:0]                   cause_q,   cause_d;
   logic                         wrst_q,    wrst_d;
   logic                         prst_q,    prst_d;
   logic                         wirq_q,    wirq_d;
   logic                         ill_q,     ill_d;
   logic                         bgnd_q,    bgnd_d;
   logic                         serr_q,    serr_d;
   logic [31:0]                  rdata_q,   rdata_d;
   logic [PWK_PRE_BITS-1:0]      pre_q,     pre_d;
   logic [PWK_CNT_BITS-1:0]      rcnt_q,    rcnt_d;
   logic                         rhit_q,    rhit_d;
   logic                         wr_en;
   logic                         rd_setup;
   logic                         ack_wr;
   logic                         stopped;
   logic                         pwk_on;
   logic [PWK_CNT_BITS-1:0]      pwk_limit;
   logic [2:0]                   pwks;
   logic                         deep_wake;
   logic                         mapped;

   localparam logic [PWK_PRE_BITS-1:0] PRE_LAST = PWK_PRE_BITS'(PWK_TICK_CYCLES - 1);

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Zero wait states; unmapped addresses answer with an error
   assign mapped   = (paddr == OFS_CTRL) || (paddr == OFS_CONFIG) || (paddr == OFS_STATUS);
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !mapped;
   assign wr_en    = psel && penable && pwrite && mapped;
   assign rd_setup = psel && !penable && !pwrite;
   assign ack_wr   = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_ACK_BIT];
   assign prdata   = rdata_q;
   assign stopped  = (state_q != SMPC_RUN);
   assign pwks     = cfg_q[CFG_PWKS_LSB +: 3];

   // Read data captured in the setup phase so it is a flop in the access phase
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (rd_setup) begin
         unique case (paddr)
            OFS_CTRL: begin
               rdata_d[CTRL_PWD_BIT]  = depth_q[0];
               rdata_d[CTRL_PART_BIT] = depth_q[1];
               rdata_d[CTRL_FLAG_BIT] = flag_q;
            end
            OFS_CONFIG: rdata_d[15:0] = cfg_q;
            OFS_STATUS: begin
               rdata_d[STAT_STATE_LSB +: 4] = state_q;
               rdata_d[STAT_CAUSE_LSB +: 3] = cause_q;
               rdata_d[STAT_LATCH_BIT]      = latch_q;
            end
            default: rdata_d = 32'h0000_0000;
         endcase
      end else begin
         rdata_d = rdata_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Periodic wakeup source
   // ----------------------------------------------------------------
   // Source dies with select zero and in the deepest stop, saving its power
   assign pwk_on    = (pwks != 3'h0) && (state_q != SMPC_STOP1);      // [R6] [R5]
   assign pwk_limit = PWK_CNT_BITS'(1) << (4'(pwks) + 4'(PWK_SHIFT_BASE));

   always_comb begin
      pre_d  = '0;
      rcnt_d = '0;
      rhit_d = 1'b0;
      if (pwk_on) begin
         pre_d  = (pre_q == PRE_LAST) ? '0 : pre_q + 1'b1;
         rcnt_d = rcnt_q;
         if (pre_q == PRE_LAST) begin
            if (rcnt_q == pwk_limit - 1'b1) begin
               rcnt_d = '0;
               rhit_d = 1'b1;                                         // [R5]
            end else begin
               rcnt_d = rcnt_q + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q  <= '0;
         rcnt_q <= '0;
         rhit_q <= 1'b0;
      end else begin
         pre_q  <= pre_d;
         rcnt_q <= rcnt_d;
         rhit_q <= rhit_d;
      end
   end

   // ----------------------------------------------------------------
   // Stop state machine, configuration and wake actions
   // ----------------------------------------------------------------
   always_comb begin
      state_d   = state_q;
      depth_d   = depth_q;
      cfg_d     = cfg_q;
      flag_d    = flag_q;
      latch_d   = latch_q;
      dbg_d     = dbg_q;
      lvr_d     = lvr_q;
      cause_d   = cause_q;
      wrst_d    = 1'b0;
      prst_d    = 1'b0;
      wirq_d    = 1'b0;
      ill_d     = 1'b0;
      bgnd_d    = 1'b0;
      serr_d    = dbg_status_query && stopped;                        // [R9]
      deep_wake = 1'b0;
      // Software writes; acknowledge clears flag and latch
      if (wr_en && paddr == OFS_CTRL) begin
         depth_d = {pwdata[CTRL_PART_BIT], pwdata[CTRL_PWD_BIT]};
         if (pwdata[CTRL_ACK_BIT]) begin
            flag_d  = 1'b0;                                           // [R22]
            latch_d = 1'b0;                                           // [R13]
         end
      end
      if (wr_en && paddr == OFS_CONFIG) begin
         cfg_d = pwdata[15:0];
      end
      unique case (state_q)
         SMPC_RUN: begin
            if (stop_exec) begin
               dbg_d = cfg_q[CFG_DBGE_BIT];                           // [R23]
               lvr_d = cfg_q[CFG_LVRE_BIT];                           // [R23]
               if (!cfg_q[CFG_ALLOW_BIT]) begin
                  ill_d = 1'b1;                                       // [R21]
               end else if (cfg_q[CFG_DBGE_BIT] || cfg_q[CFG_LVRE_BIT] || !depth_q[0]) begin
                  state_d = SMPC_STOP3;                               // [R8] [R11] [R20]
               end else if (depth_q[1]) begin
                  state_d = SMPC_STOP2;                               // [R20]
                  latch_d = 1'b1;                                     // [R13]
               end else begin
                  state_d = SMPC_STOP1;                               // [R20]
               end
            end
         end
         SMPC_STOP1, SMPC_STOP2: begin
            // Wake pins are active low here whatever their old setup
            if (!reset_pin_n) begin
               cause_d   = CAUSE_RSTPIN;
               deep_wake = 1'b1;
            end else if (cfg_q[CFG_IRQE_BIT] && !irq_pin_n) begin
               cause_d   = CAUSE_IRQ;
               deep_wake = 1'b1;
            end else if ((cfg_q[CFG_KBE_LSB +: 8] & ~keypad_pins_n) != 8'h00) begin
               cause_d   = CAUSE_KEYPAD;                              // [R18]
               deep_wake = 1'b1;
            end else if (state_q == SMPC_STOP2 && rhit_q) begin
               cause_d   = CAUSE_PWK;                                 // [R5]
               deep_wake = 1'b1;
            end
            if (deep_wake) begin
               state_d = SMPC_RUN;
               wrst_d  = 1'b1;                                        // [R15]
               prst_d  = 1'b1;                                        // [R16] [R17]
               depth_d = RST_DEPTH;
               cfg_d   = RST_CONFIG;                                  // [R15]
               if (state_q == SMPC_STOP2) begin
                  flag_d = 1'b1;                                      // [R22]
               end
            end
         end
         SMPC_STOP3: begin
            if (!reset_pin_n) begin
               state_d = SMPC_RUN;
               cause_d = CAUSE_RSTPIN;
               wrst_d  = 1'b1;                                        // [R4]
            end else if (dbg_q && dbg_background_cmd) begin
               state_d = SMPC_RUN;
               cause_d = CAUSE_BGND;
               bgnd_d  = 1'b1;                                        // [R10]
            end else if (irq_req || keypad_irq || rhit_q) begin
               state_d = SMPC_RUN;                                    // [R3]
               cause_d = irq_req ? CAUSE_IRQ : (keypad_irq ? CAUSE_KEYPAD : CAUSE_PWK);
               wirq_d  = 1'b1;                                        // [R4]
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= SMPC_RUN;
         depth_q <= RST_DEPTH;
         cfg_q   <= RST_CONFIG;
         flag_q  <= 1'b0;
         latch_q <= 1'b0;
         dbg_q   <= 1'b0;
         lvr_q   <= 1'b0;
         cause_q <= CAUSE_NONE;
         wrst_q  <= 1'b0;
         prst_q  <= 1'b0;
         wirq_q  <= 1'b0;
         ill_q   <= 1'b0;
         bgnd_q  <= 1'b0;
         serr_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         depth_q <= depth_d;
         cfg_q   <= cfg_d;
         flag_q  <= flag_d;
         latch_q <= latch_d;
         dbg_q   <= dbg_d;
         lvr_q   <= lvr_d;
         cause_q <= cause_d;
         wrst_q  <= wrst_d;
         prst_q  <= prst_d;
         wirq_q  <= wirq_d;
         ill_q   <= ill_d;
         bgnd_q  <= bgnd_d;
         serr_q  <= serr_d;
      end
   end

   // ----------------------------------------------------------------
   // Power, clock and pin controls
   // ----------------------------------------------------------------
   // All decoded from flops, so they change one edge after entry
   assign cpu_clk_en         = !stopped;                                  // [R1]
   assign periph_clk_en      = !stopped;                                  // [R12] [R16]
   assign osc_en             = !stopped || dbg_q || lvr_q;                // [R1] [R8]
   assign regulator_full     = !stopped || dbg_q || lvr_q;                // [R19] [R7] [R11]
   assign debug_clk_en       = !stopped || dbg_q;                         // [R7]
   assign comparator_standby = stopped;                                   // [R17] [R1]
   assign ram_retain         = (state_q != SMPC_STOP1);                   // [R2] [R15]
   assign pins_latched       = latch_q;                                   // [R13]
   assign pins_force_default = (state_q == SMPC_STOP1);                   // [R14]
   assign keypad_wake_mode   = (state_q == SMPC_STOP1) || (state_q == SMPC_STOP2); // [R18]
   assign pwk_src_en         = pwk_on;                                    // [R6]
   assign pwk_irq            = rhit_q && !stopped;
   assign dbg_cmds_avail     = !stopped;                                  // [R9]
   assign dbg_status_err     = serr_q;
   assign dbg_enter_background = bgnd_q;
   assign wake_reset         = wrst_q;
   assign periph_reset       = prst_q;
   assign wake_irq           = wirq_q;
   assign wake_cause         = cause_q;
   assign illegal_op_reset   = ill_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_stop_disallowed: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
      (state_q == SMPC_RUN && stop_exec && !cfg_q[CFG_ALLOW_BIT])
      |=> (illegal_op_reset && state_q == SMPC_RUN))
      else $error("disallowed stop did not force illegal reset");

   a_override_shallow: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
      (state_q == SMPC_RUN && stop_exec && cfg_q[CFG_ALLOW_BIT]
       && (cfg_q[CFG_DBGE_BIT] || cfg_q[CFG_LVRE_BIT]))
      |=> (state_q == SMPC_STOP3 && osc_en && regulator_full))
       else $error("override did not give shallow stop with power on");

   a_depth_deep: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
      (state_q == SMPC_RUN && stop_exec && cfg_q[2:0] == 3'b001 && depth_q == 2'b01)
      |=> (state_q == SMPC_STOP1 && pins_force_default && !ram_retain))
      else $error("deepest stop not entered");

   a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
      (pins_latched && !ack_wr) |=> pins_latched)
      else $error("pin latch released without acknowledge");

   a_stop_clocks: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
      stopped |-> (!periph_clk_en && !cpu_clk_en && comparator_standby))
      else $error("clocks running in stop");

   a_reg_standby: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
      (stopped && !dbg_q && !lvr_q) |-> (!regulator_full && !osc_en && !debug_clk_en))
      else $error("regulator not in standby");

   a_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // [R22]
      (state_q == SMPC_STOP2 && state_d == SMPC_RUN)
      |=> (flag_q && wake_reset && periph_reset) ##1 !wake_reset)
      else $error("intermediate wake flag or reset missing");

   a_irq_wake: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
      (state_q == SMPC_STOP3 && reset_pin_n && !(dbg_q && dbg_background_cmd) && irq_req)
      |=> (wake_irq && !wake_reset && wake_cause == CAUSE_IRQ && !stopped))
      else $error("interrupt wake from shallow stop wrong");

   a_pwk_off: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
      (pwks == 3'h0) [*2] |-> (!pwk_src_en && !rhit_q))
      else $error("periodic source active with select zero");

   a_status_err: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
      (dbg_status_query && stopped) |=> dbg_status_err)
      else $error("status query in stop gave no error");

   c_stop1_wake: cover property (@(posedge pclk) disable iff (!presetn)
      state_q == SMPC_STOP1 ##1 wake_reset);
   c_stop2_pwk: cover property (@(posedge pclk) disable iff (!presetn)
      state_q == SMPC_STOP2 ##1 (wake_reset && wake_cause == CAUSE_PWK));
   c_stop3_bgnd: cover property (@(posedge pclk) disable iff (!presetn)
      state_q == SMPC_STOP3 ##1 dbg_enter_background);
   c_stop3_irq: cover property (@(posedge pclk) disable iff (!presetn)
      state_q == SMPC_STOP3 ##1 wake_irq);

endmodule

/* src/smpc_pkg.sv */
// Constants, register map and state codes of the stop-mode power controller.
// Assumes a 100 MHz APB clock; the controller and the bench import this package.
package smpc_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 10;          // pclk at 100 MHz
   localparam int PWK_TICK_NS     = 1_000_000;   // Source tick counted from pclk, about 1 kHz
   localparam int PWK_TICK_CYCLES = (PWK_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PWK_PRE_BITS    = 17;
   localparam int PWK_CNT_BITS    = 10;
   localparam int PWK_SHIFT_BASE  = 2;           // Period in ticks is 2^(select + base)

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;    // power_mgmt_control_two
   localparam logic [7:0] OFS_CONFIG = 8'h04;    // power_mgmt_control_one and options
   localparam logic [7:0] OFS_STATUS = 8'h08;    // Read-only state view

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_PWD_BIT   = 0;            // power_down_select
   localparam int CTRL_PART_BIT  = 1;            // partial_power_down_select
   localparam int CTRL_ACK_BIT   = 2;            // pin_latch_release_ack, write one
   localparam int CTRL_FLAG_BIT  = 3;            // partial_down_wake_flag, read only
   localparam int CFG_ALLOW_BIT  = 0;            // stop_instruction_allow
   localparam int CFG_LVRE_BIT   = 1;            // low_voltage_reset_enable
   localparam int CFG_DBGE_BIT   = 2;            // debug_entry_enable
   localparam int CFG_IRQE_BIT   = 3;            // Wake pin enable
   localparam int CFG_PWKS_LSB   = 4;            // periodic_wake_period_select [6:4]
   localparam int CFG_KBE_LSB    = 8;            // Keypad pin enables [15:8]
   localparam int STAT_STATE_LSB = 0;            // State code [3:0]
   localparam int STAT_CAUSE_LSB = 4;            // Last wake cause [6:4]
   localparam int STAT_LATCH_BIT = 8;            // Pins latched

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [1:0]  RST_DEPTH  = 2'b00;
   localparam logic [15:0] RST_CONFIG = 16'h0000;

   // ----------------------------------------------------------------
   // States and wake causes
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      SMPC_RUN   = 4'b0001,
      SMPC_STOP1 = 4'b0010,
      SMPC_STOP2 = 4'b0100,
      SMPC_STOP3 = 4'b1000
   } smpc_state_t;

   localparam logic [2:0] CAUSE_NONE   = 3'h0;
   localparam logic [2:0] CAUSE_RSTPIN = 3'h1;
   localparam logic [2:0] CAUSE_IRQ    = 3'h2;
   localparam logic [2:0] CAUSE_KEYPAD = 3'h3;
   localparam logic [2:0] CAUSE_PWK    = 3'h4;
   localparam logic [2:0] CAUSE_BGND   = 3'h5;

endpackage

/* sim/smpc_far_model.sv */
// Far-side model: core stop pulses, wake pins and debug host commands.
// Assumes the bench calls pulse() from its own thread, one source at a time.
`timescale 1ns/1ns
module smpc_far_model (
   // Clock
   input  wire logic       pclk,
   // Core, pins and debug host
   output logic            stop_exec,
   output logic            reset_pin_n,
   output logic            irq_pin_n,
   output logic            irq_req,
   output logic            keypad_irq,
   output logic            dbg_background_cmd,
   output logic            dbg_status_query,
   output logic [7:0]      keypad_pins_n
);
   // -----------------------------------------------
   // Source levels, active-low pins idle high
   // -----------------------------------------------
   logic [7:0] act_q = 8'h00;
   assign stop_exec          = act_q[0];
   assign reset_pin_n        = ~act_q[1];
   assign irq_pin_n          = ~act_q[2];
   assign irq_req            = act_q[3];
   assign keypad_irq         = act_q[4];
   assign dbg_background_cmd = act_q[5]; // Host can send this to wake from debug stop
   assign dbg_status_query   = act_q[6];
   assign keypad_pins_n      = {8{~act_q[7]}};
   // One cycle per request, so a source never lingers into the next test
   task automatic pulse(input int k);
      @(posedge pclk);
      act_q[k] <= 1'b1;
      @(posedge pclk);
      act_q[k] <= 1'b0;
      #1;
   endtask
endmodule

/* sim/smpc_ctrl_tb.sv */
// Self-checking bench for the stop-mode controller.
// Assumes zero-wait APB and the far-side model driving all wake sources.
`timescale 1ns/1ns
module smpc_ctrl_tb;
   import smpc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, seen;
   logic [7:0] paddr = 8'h00, keypad_pins_n;
   logic [31:0] pwdata = 32'h0000_0000, prdata, r;
   logic [2:0] wake_cause;
   logic pready, pslverr, e, stop_exec, illegal_op_reset, cpu_clk_en, wake_reset, wake_irq, pwk_irq, osc_en;
   logic regulator_full, periph_clk_en, periph_reset, comparator_standby, ram_retain, pwk_src_en, reset_pin_n;
   logic irq_pin_n, irq_req, keypad_irq, pins_latched, pins_force_default, keypad_wake_mode, dbg_background_cmd;
   logic dbg_status_query, debug_clk_en, dbg_cmds_avail, dbg_status_err, dbg_enter_background;
   int mismatches = 0, check_count = 0;
   always #5 pclk = ~pclk;
   smpc_ctrl #(.PWK_TICK_CYCLES(4)) u_smpc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .stop_exec, .illegal_op_reset, .cpu_clk_en, .wake_reset, .wake_irq, .wake_cause,
      .pwk_irq, .osc_en, .regulator_full, .periph_clk_en, .periph_reset, .comparator_standby, .ram_retain,
      .pwk_src_en, .reset_pin_n, .irq_pin_n, .irq_req, .keypad_pins_n, .keypad_irq, .pins_latched,
      .pins_force_default, .keypad_wake_mode, .dbg_background_cmd, .dbg_status_query, .debug_clk_en,
      .dbg_cmds_avail, .dbg_status_err, .dbg_enter_background);
   smpc_far_model u_smpc_far_model (.pclk, .stop_exec, .reset_pin_n, .irq_pin_n, .irq_req, .keypad_irq,
      .dbg_background_cmd, .dbg_status_query, .keypad_pins_n);
   // -----------------------------------------------
   // Shared tasks
   // -----------------------------------------------
   task chk(input logic [63:0] g, input logic [63:0] x);
      check_count++;
      if (g !== x) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Request held until pready seen high; data and error taken at that edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   // Program options and depth, then execute a stop
   task go(input logic [31:0] c, input logic [31:0] d);
      apb(1'b1, OFS_CONFIG, c);
      apb(1'b1, OFS_CTRL, d);
      u_smpc_far_model.pulse(0);
   endtask
   // -----------------------------------------------
   // Scenarios
   // -----------------------------------------------
   task t_regs;
      apb(1'b0, OFS_STATUS, 0);
      chk(r, 32'h0000_0001);
      apb(1'b1, OFS_CONFIG, 32'h1234_5670);
      apb(1'b0, OFS_CONFIG, 0);
      chk(r, 32'h0000_5670);
      apb(1'b0, 8'h0c, 0);
      chk(e, 1'b1);
   endtask
   task t_deep;
      go(32'h0000_0001, 32'h0000_0001);
      chk({pins_force_default, ram_retain, periph_clk_en, osc_en, regulator_full, cpu_clk_en}, 6'h20);
      u_smpc_far_model.pulse(1);
      chk({wake_reset, periph_reset, wake_cause}, {2'b11, CAUSE_RSTPIN});
      go(32'h0000_0101, 32'h0000_0001);
      u_smpc_far_model.pulse(7);
      chk(wake_cause, CAUSE_KEYPAD);
   endtask
   task t_mid;
      go(32'h0000_0011, 32'h0000_0003);
      repeat (40) @(posedge pclk);
      chk(wake_cause, CAUSE_PWK);
      go(32'h0000_0009, 32'h0000_0003);
      chk({pins_latched, keypad_wake_mode, ram_retain, periph_clk_en}, 4'he);
      u_smpc_far_model.pulse(2);
      chk({wake_reset, wake_cause}, {1'b1, CAUSE_IRQ});
      apb(1'b0, OFS_CTRL, 0);
      chk({r, pins_latched}, {32'h0000_0008, 1'b1});
      apb(1'b1, OFS_CTRL, 32'h0000_0004);
      apb(1'b0, OFS_CTRL, 0);
      chk({r, pins_latched}, 33'h0);
   endtask
   task t_shallow;
      go(32'h0000_0009, 32'h0000_0000);
      chk({osc_en, regulator_full, comparator_standby, periph_clk_en, pins_latched, pwk_src_en}, 6'h08);
      apb(1'b0, OFS_STATUS, 0);
      chk(r[3:0], SMPC_STOP3);
      u_smpc_far_model.pulse(3);
      chk({wake_irq, wake_reset, cpu_clk_en, wake_cause}, {3'b101, CAUSE_IRQ});
   endtask
   task t_lvr;
      go(32'h0000_ff03, 32'h0000_0001);
      apb(1'b0, OFS_STATUS, 0);
      chk({r[3:0], regulator_full, periph_clk_en}, {SMPC_STOP3, 2'b10});
      u_smpc_far_model.pulse(4);
      chk({wake_irq, wake_cause}, {1'b1, CAUSE_KEYPAD});
   endtask
   task t_debug;
      go(32'h0000_0005, 32'h0000_0003);
      apb(1'b0, OFS_STATUS, 0);
      chk({r[3:0], debug_clk_en, regulator_full, osc_en, periph_clk_en}, {SMPC_STOP3, 4'he});
      u_smpc_far_model.pulse(6);
      chk({dbg_status_err, dbg_cmds_avail}, 2'b10);
      u_smpc_far_model.pulse(5);
      chk({dbg_enter_background, wake_cause}, {1'b1, CAUSE_BGND});
   endtask
   task t_illegal;
      go(32'h0000_0000, 32'h0000_0001);
      seen = illegal_op_reset;
      repeat (2) begin
         @(posedge pclk);
         #1 seen = seen | illegal_op_reset;
      end
      apb(1'b0, OFS_STATUS, 0);
      chk({seen, r[3:0]}, {1'b1, SMPC_RUN});
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_deep;
      t_mid;
      t_shallow;
      t_lvr;
      t_debug;
      t_illegal;
      end_sim;
   end
   // Whole run is under two hundred cycles
   initial begin
      #300000;
      mismatches++;
      end_sim;
   end
endmodule
